// >>> hdl/isdtb_core.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module isdtb_core #(
  parameter int FRAME_CYC = isdtb_pkg::FRAME_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic layer1_bus_clock,
  input wire logic layer1_rx_line,
  input wire logic frame_sync_in,
  input wire logic dchan_grant_in,
  output logic layer1_tx_out,
  output logic layer1_tx_oe,
  output logic dchan_request_out,
  output logic bearer_strobe_first,
  output logic bearer_strobe_second,
  output logic bus_data_rate_clock,
  input wire logic dchan_pending,
  output logic dchan_abort,
  input wire logic [2:0] ser_tx_bit,
  output logic [2:0] ser_tx_take,
  output logic [2:0] ser_rx_bit,
  output logic [2:0] ser_rx_valid,
  input wire logic [1:0] mgmt_tx_bit,
  output logic [1:0] mgmt_rx_bit,
  output logic [1:0] mgmt_rx_valid
);
  typedef struct packed {
    logic [2:0] ck;
    logic [1:0] rx;
    logic [1:0] sy;
    logic [1:0] gr;
    logic phase;
    logic active;
    logic d_ok;
    logic dcl;
    logic drive;
    logic txb;
    logic stb1;
    logic stb2;
    logic req;
    logic abort;
    logic lost;
    logic [6:0] cnt;
    logic [13:0] wd;
    logic [7:0] aborts;
    logic [2:0] ctrl;
    logic [15:0] mask;
    logic [5:0] route;
    logic [31:0] rdata;
    logic [2:0] stake;
    logic [2:0] srx_b;
    logic [2:0] srx_v;
    logic [1:0] mrx_b;
    logic [1:0] mrx_v;
  } isdtb_state_s;

  isdtb_state_s st;
  isdtb_state_s nx;

  ////////////////////////////////////////////////////////////////////////////
  // Frame slot decode

  function automatic isdtb_pkg::isdtb_kind_e kind_of(input logic g, input logic [6:0] p);
    kind_of = isdtb_pkg::K_NONE;
    if (!g) begin
      if (p < isdtb_pkg::IDL_D0) begin
        kind_of = isdtb_pkg::K_B1;
      end else if (p == isdtb_pkg::IDL_D0 || p == isdtb_pkg::IDL_D1) begin
        kind_of = isdtb_pkg::K_D;
      end else if (p == isdtb_pkg::IDL_A) begin
        kind_of = isdtb_pkg::K_A;
      end else if (p < isdtb_pkg::IDL_D1) begin
        kind_of = isdtb_pkg::K_B2;
      end else if (p == isdtb_pkg::IDL_LAST) begin
        kind_of = isdtb_pkg::K_M;
      end
    end else begin
      if (p < isdtb_pkg::GCI_B2) begin
        kind_of = isdtb_pkg::K_B1;
      end else if (p < isdtb_pkg::GCI_MON) begin
        kind_of = isdtb_pkg::K_B2;
      end else if (p < isdtb_pkg::GCI_D) begin
        kind_of = isdtb_pkg::K_M;
      end else if (p < isdtb_pkg::GCI_CI) begin
        kind_of = isdtb_pkg::K_D;
      end else if (p < isdtb_pkg::GCI_CH1) begin
        kind_of = isdtb_pkg::K_A;
      end else if (p == isdtb_pkg::GCI_SCIT) begin
        kind_of = isdtb_pkg::K_S;
      end
    end
  endfunction

  function automatic logic [3:0] mask_idx(input logic g, input logic [6:0] p);
    logic [6:0] b2;
    logic [6:0] d;
    b2 = g ? isdtb_pkg::GCI_B2 : isdtb_pkg::IDL_B2;
    d = (p >= b2) ? p - b2 : p;
    mask_idx = {p >= b2, d[2:0]};
  endfunction

  function automatic logic [1:0] sel_of(input isdtb_pkg::isdtb_kind_e k, input logic [5:0] r);
    sel_of = isdtb_pkg::ROUTE_OFF;
    if (k == isdtb_pkg::K_D) begin
      sel_of = r[1:0];
    end else if (k == isdtb_pkg::K_B1) begin
      sel_of = r[3:2];
    end else if (k == isdtb_pkg::K_B2) begin
      sel_of = r[5:4];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic gci;
    logic rise;
    logic fall;
    logic tick;
    logic rbit;
    logic [6:0] tp;
    logic [1:0] sel;
    isdtb_pkg::isdtb_kind_e k;
    nx = st;
    gci = st.ctrl[0];
    rise = st.ck[1] & ~st.ck[2];
    fall = ~st.ck[1] & st.ck[2];
    tick = 1'b0;
    tp = st.cnt + 7'h01;
    sel = isdtb_pkg::ROUTE_OFF;
    k = isdtb_pkg::K_NONE;
    rbit = 1'b1;
    nx.ck = {st.ck[1:0], layer1_bus_clock};
    nx.rx = {st.rx[0], layer1_rx_line};
    nx.sy = {st.sy[0], frame_sync_in};
    nx.gr = {st.gr[0], dchan_grant_in};
    nx.stake = 3'h0;
    nx.srx_v = 3'h0;
    nx.mrx_v = 2'h0;
    nx.abort = 1'b0;
    nx.req = ~gci & dchan_pending;
    nx.wd = st.wd + 14'h0001;
    if (st.wd == 14'(2 * FRAME_CYC)) begin
      nx.wd = st.wd;
      nx.lost = 1'b1;
    end
    // Bit clock from the transceiver, frame starts at sync
    if (rise) begin
      nx.phase = ~st.phase;
      nx.dcl = gci & ~st.dcl;
      if (st.sy[1]) begin
        nx.cnt = 7'h00;
        nx.active = 1'b1;
        nx.phase = 1'b1;
        nx.wd = 14'h0000;
        nx.lost = 1'b0;
        if (!gci) begin
          nx.d_ok = st.gr[1];
        end
        tp = 7'h00;
        tick = 1'b1;
      end else if (st.active && (!gci || !st.phase)) begin
        if (st.cnt == (gci ? isdtb_pkg::GCI_LAST : isdtb_pkg::IDL_LAST)) begin
          nx.active = 1'b0;
          nx.drive = 1'b0;
          nx.stb1 = 1'b0;
          nx.stb2 = 1'b0;
        end else begin
          nx.cnt = tp;
          tick = 1'b1;
        end
      end
    end
    // Transmit side, one slot per tick
    if (tick) begin
      k = kind_of(gci, tp);
      sel = sel_of(k, st.route);
      nx.drive = 1'b0;
      nx.txb = 1'b1;
      nx.stb1 = 1'b0;
      nx.stb2 = 1'b0;
      if (st.ctrl[1]) begin
        nx.drive = 1'b1;
        nx.txb = st.rx[1];
      end else if (k == isdtb_pkg::K_B1 || k == isdtb_pkg::K_B2) begin
        if (st.mask[mask_idx(gci, tp)]) begin
          nx.stb1 = (k == isdtb_pkg::K_B1);
          nx.stb2 = (k == isdtb_pkg::K_B2);
          if (sel != isdtb_pkg::ROUTE_OFF) begin
            nx.drive = 1'b1;
            nx.txb = ser_tx_bit[sel];
            nx.stake[sel] = 1'b1;
          end
        end
      end else if (k == isdtb_pkg::K_D) begin
        if (st.d_ok && dchan_pending && sel != isdtb_pkg::ROUTE_OFF) begin
          nx.drive = 1'b1;
          nx.txb = ser_tx_bit[sel];
          nx.stake[sel] = 1'b1;
        end
      end else if (k == isdtb_pkg::K_M) begin
        nx.drive = 1'b1;
        nx.txb = mgmt_tx_bit[0];
      end else if (k == isdtb_pkg::K_A) begin
        nx.drive = 1'b1;
        nx.txb = mgmt_tx_bit[1];
      end
    end
    // Receive side, sampled on the falling edge: mid-bit on the frame bus, on the second falling edge of the bit on the serial bus
    if (fall && st.active && (!gci || !st.phase)) begin
      rbit = st.ctrl[2] ? ~(st.drive & ~st.txb) : st.rx[1];
      k = kind_of(gci, st.cnt);
      sel = sel_of(k, st.route);
      if (k == isdtb_pkg::K_S) begin
        if (rbit && st.d_ok && dchan_pending) begin
          nx.abort = 1'b1;
          nx.aborts = st.aborts + 8'h01;
        end
        nx.d_ok = ~rbit;
      end else if (k == isdtb_pkg::K_M || k == isdtb_pkg::K_A) begin
        nx.mrx_v[k == isdtb_pkg::K_A] = 1'b1;
        nx.mrx_b[k == isdtb_pkg::K_A] = rbit;
      end else if (sel != isdtb_pkg::ROUTE_OFF) begin
        if (k == isdtb_pkg::K_D || st.mask[mask_idx(gci, st.cnt)]) begin
          nx.srx_v[sel] = 1'b1;
          nx.srx_b[sel] = rbit;
        end
      end
    end
    // Grant taken away while signaling is on the line
    if (!gci && st.active && st.d_ok && dchan_pending && !st.gr[1]) begin
      nx.d_ok = 1'b0;
      nx.abort = 1'b1;
      nx.aborts = st.aborts + 8'h01;
      if (kind_of(gci, nx.cnt) == isdtb_pkg::K_D) begin
        nx.drive = 1'b0;
      end
    end
    // Register bus
    if (psel && !penable) begin
      nx.rdata = 32'h0000_0000;
      if (paddr == isdtb_pkg::A_CTRL) begin
        nx.rdata[2:0] = st.ctrl;
      end else if (paddr == isdtb_pkg::A_MASK) begin
        nx.rdata[15:0] = st.mask;
      end else if (paddr == isdtb_pkg::A_ROUTE) begin
        nx.rdata[5:0] = st.route;
      end else if (paddr == isdtb_pkg::A_STAT) begin
        nx.rdata[15:0] = {st.aborts, 5'h00, st.lost, st.d_ok, st.active};
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == isdtb_pkg::A_CTRL) begin
        nx.ctrl = pwdata[2:0];
      end else if (paddr == isdtb_pkg::A_MASK) begin
        nx.mask = pwdata[15:0];
      end else if (paddr == isdtb_pkg::A_ROUTE) begin
        nx.route = pwdata[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl <= isdtb_pkg::CTRL_RST;
      st.mask <= isdtb_pkg::MASK_RST;
      st.route <= isdtb_pkg::ROUTE_RST;
      st.rx <= 2'h3;
      st.gr <= 2'h0;
      st.txb <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != isdtb_pkg::A_CTRL) &
                   (paddr != isdtb_pkg::A_MASK) & (paddr != isdtb_pkg::A_ROUTE) &
                   (paddr != isdtb_pkg::A_STAT);
  assign layer1_tx_out = st.txb & ~st.ctrl[0];
  assign layer1_tx_oe = st.drive & (~st.ctrl[0] | ~st.txb);
  assign dchan_request_out = st.req;
  assign bearer_strobe_first = st.stb1;
  assign bearer_strobe_second = st.stb2;
  assign bus_data_rate_clock = st.dcl;
  assign dchan_abort = st.abort;
  assign ser_tx_take = st.stake;
  assign ser_rx_bit = st.srx_b;
  assign ser_rx_valid = st.srx_v;
  assign mgmt_rx_bit = st.mrx_b;
  assign mgmt_rx_valid = st.mrx_v;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  localparam int IDL_LAST_I = 19;

  a_req_pending:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(dchan_pending) && !st.ctrl[0] && !nx.ctrl[0] |=> dchan_request_out)
    else $error("request not raised for pending data");
  a_float_idle:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !st.active |-> !layer1_tx_oe)
    else $error("transmit line driven outside frame");
  a_open_drain:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      st.ctrl[0] && layer1_tx_oe |-> !layer1_tx_out)
    else $error("serial-bus line driven high");
  a_strobe_frame:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      bearer_strobe_first || bearer_strobe_second |-> st.active &&
      !(bearer_strobe_first && bearer_strobe_second))
    else $error("strobe outside bearer bits");
  a_frame_len:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      st.active && !st.ctrl[0] |-> int'(st.cnt) <= IDL_LAST_I)
    else $error("frame-bus frame longer than 20 bits");
  a_dcl_toggle:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      st.ctrl[0] && st.ck[1] && !st.ck[2] |=> bus_data_rate_clock != $past(bus_data_rate_clock))
    else $error("data-rate clock missed a bus clock edge");
  a_grant_abort:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !st.ctrl[0] && st.active && st.d_ok && dchan_pending && !st.gr[1]
      |=> dchan_abort ##1 !st.d_ok)
    else $error("grant loss not aborting");
  a_rx_frame_only:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (|ser_rx_valid) || (|mgmt_rx_valid) |-> $past(st.active))
    else $error("receive outside frame");
  a_sync_start:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      st.sy[1] && st.ck[1] && !st.ck[2] |=> st.active && st.cnt == 7'h00)
    else $error("sync did not start frame");
  a_abort_pulse:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      dchan_abort |=> !dchan_abort)
    else $error("abort pulse longer than one cycle");
  a_req_gci_off:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      st.ctrl[0] |=> !dchan_request_out)
    else $error("request raised in serial-bus mode");
  a_dcl_frame_bus:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !st.ctrl[0] && st.ck[1] && !st.ck[2] |=> !bus_data_rate_clock)
    else $error("data-rate clock running in frame-bus mode");
  a_first_strobe_slot:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      bearer_strobe_first |-> kind_of(st.ctrl[0], st.cnt) == isdtb_pkg::K_B1)
    else $error("first strobe outside first bearer");
  a_second_strobe_slot:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      bearer_strobe_second |-> kind_of(st.ctrl[0], st.cnt) == isdtb_pkg::K_B2)
    else $error("second strobe outside second bearer");
  a_d_slot_permit:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      layer1_tx_oe && !st.ctrl[1] && kind_of(st.ctrl[0], st.cnt) == isdtb_pkg::K_D
      |-> st.d_ok)
    else $error("signaling slot driven without permission");
endmodule

// >>> hdl/isdtb_pkg.sv
// Function
// - Frame-bus mode carries five channels in a 20-bit frame every 125 us.
// - Frame bus is slave only; the transceiver supplies bit clock and sync.
// - Only the 10-bit frame-bus layout exists; the 8-bit one is absent.
// - Two strobes mark first and second bearer, only on unmasked bits.
// - Frame-bus transmit line driven only on supported bits, floated elsewhere.
// - Receive line taken only during the 20 frame bits.
// - A sync pulse starts the frame of the following 20 clock periods.
// - Channels: two 64k bearers, 16k signaling, 8k maintenance, 8k auxiliary.
// - Signaling and bearers route to any controller; maintenance and auxiliary fixed.
// - Request output is raised while signaling data is pending; the code raises it in frame-bus mode only, never in serial-bus mode.
// - Grant sampled at sync; if high, signaling sends from its first bit.
// - Grant lost mid-frame stops sending; controller resends on return.
// - Per-bit bearer mask: only enabled bits received, sent, else floated.
// - Serial-bus mode: normal channel 0 and channel 2 access control only.
// - Serial bus: 8 kHz frame at 768 kbps, sync marks the channel.
// - In serial-bus mode the transmit line only pulls low or releases.
// - Serial-bus mode outputs a data-rate clock at half the bus clock.
// - Serial frame: bearers, monitor 8 bits, signaling 2, command field 6.
// - Echo mode retransmits the whole received stream.
// - Loopback feeds transmitted line back into the receiver path.
// - Serial-bus collision bit of channel 2 command field aborts sending.
// - Serial-bus mode sends only enabled bearer bits, line released otherwise.
package isdtb_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_ROUTE = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [5:0] ROUTE_RST = 6'h24;
  localparam logic [1:0] ROUTE_OFF = 2'h3;
  localparam int FRAME_US = 125;
  localparam int CLK_NS = 25;
  localparam int FRAME_CYC = FRAME_US * 1000 / CLK_NS;
  localparam logic [6:0] IDL_B2 = 7'h0A;
  localparam logic [6:0] IDL_D0 = 7'h08;
  localparam logic [6:0] IDL_A = 7'h09;
  localparam logic [6:0] IDL_D1 = 7'h12;
  localparam logic [6:0] IDL_LAST = 7'h13;
  localparam logic [6:0] GCI_B2 = 7'h08;
  localparam logic [6:0] GCI_MON = 7'h10;
  localparam logic [6:0] GCI_D = 7'h18;
  localparam logic [6:0] GCI_CI = 7'h1A;
  localparam logic [6:0] GCI_CH1 = 7'h20;
  localparam logic [6:0] GCI_SCIT = 7'h5B;
  localparam logic [6:0] GCI_LAST = 7'h5F;
  typedef enum logic [2:0] {
    K_NONE = 3'b000, K_B1 = 3'b001, K_B2 = 3'b010, K_D = 3'b011,
    K_M = 3'b100, K_A = 3'b101, K_S = 3'b110
  } isdtb_kind_e;
endpackage

// >>> sim/isdtb_xcvr_model.sv
`timescale 1ns/1ps
module isdtb_xcvr_model (
  output logic link_clk,
  output logic sync,
  output logic rx,
  output logic grant,
  input wire logic tx_line
);
  logic [15:0] lfsr = 16'hACE1;
  logic in_frame = 1'h0;
  initial begin
    link_clk = 1'h0;
    sync = 1'h0;
    rx = 1'h1;
    grant = 1'h1;
  end
  // Released line shows a changing pattern between frames
  always #25 if (!in_frame) rx = ~rx;
  ////////////////////////////////////////////////////////////////////////
  // Bus master: 200 ns bit clock, one-period sync, grant while D is free
  task automatic run_frame(input int n, input int drop);
    in_frame = 1'h1;
    for (int i = 0; i < n; i++) begin
      sync <= (i == 0);
      grant <= !(drop != 0 && i >= drop);
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rx <= lfsr[0];
      link_clk <= 1'h1;
      #100;
      link_clk <= 1'h0;
      #100;
    end
    sync <= 1'h0;
    grant <= 1'h1;
    in_frame = 1'h0;
  endtask
endmodule

// >>> sim/tb_isdn_tdm_bus_interface.sv
`timescale 1ns/1ps
module tb_isdn_tdm_bus_interface;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pending = 1'h0, clr = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] seed = 32'h7783;
  logic pready, pslverr, tx_out, tx_oe, req, sf, ss, dclk, abort, err, dk_q;
  logic lclk, sync, rx, grant;
  logic [2:0] ser_tx = 3'h0, rxb, rxv;
  logic [1:0] mg_tx = 2'h0, mrxb, mrxv;
  logic [15:0] m;
  logic [11:0] ev;
  logic [2:0] take;
  wire tx_line = tx_oe ? tx_out : 1'h1;
  int cnt [12];
  int fails = 0, comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  isdtb_core #(.FRAME_CYC(500)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .layer1_bus_clock(lclk), .layer1_rx_line(rx),
    .frame_sync_in(sync), .dchan_grant_in(grant), .layer1_tx_out(tx_out),
    .layer1_tx_oe(tx_oe), .dchan_request_out(req), .bearer_strobe_first(sf),
    .bearer_strobe_second(ss), .bus_data_rate_clock(dclk), .dchan_pending(pending),
    .dchan_abort(abort), .ser_tx_bit(ser_tx), .ser_tx_take(take), .ser_rx_bit(rxb),
    .ser_rx_valid(rxv), .mgmt_tx_bit(mg_tx), .mgmt_rx_bit(mrxb), .mgmt_rx_valid(mrxv));
  isdtb_xcvr_model u_xcvr (.link_clk(lclk), .sync(sync), .rx(rx), .grant(grant),
    .tx_line(tx_line));
  ////////////////////////////////////////////////////////////////////////
  // Event counters over one frame window
  assign ev = {take[1], tx_oe & tx_out, rxv[1] & rxb[1], dclk ^ dk_q, abort, mrxv[1],
    mrxv[0], rxv[2], rxv[1], tx_oe, ss, sf};
  always @(posedge clk_sys) begin
    dk_q <= dclk;
    for (int k = 0; k < 12; k++) cnt[k] <= clr ? 0 : cnt[k] + ((ev[k] === 1'h0) ? 0 : 1);
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic int pc(input logic [7:0] v);
    pc = 0;
    for (int k = 0; k < 8; k++) pc += int'(v[k]);
  endfunction
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic frame(input int n, input int drop);
    clr <= 1'h1;
    @(posedge clk_sys);
    clr <= 1'h0;
    u_xcvr.run_frame(n, drop);
    repeat (20) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'h1;
    apb(1'h0, isdtb_pkg::A_CTRL, 32'h0);
    chk("ctrl", rd, {29'h0, isdtb_pkg::CTRL_RST});
    apb(1'h0, isdtb_pkg::A_MASK, 32'h0);
    chk("mask", rd, {16'h0, isdtb_pkg::MASK_RST});
    apb(1'h0, isdtb_pkg::A_ROUTE, 32'h0);
    chk("route", rd, {26'h0, isdtb_pkg::ROUTE_RST});
    apb(1'h1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      m = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
      ser_tx <= seed[18:16];
      mg_tx <= seed[20:19];
      apb(1'h1, isdtb_pkg::A_MASK, {16'h0, m});
      frame(21, 0);
      chk("strobe1", cnt[0], 8 * pc(m[7:0]));
      chk("strobe2", cnt[1], 8 * pc(m[15:8]));
      chk("b1 rx", cnt[3], pc(m[7:0]));
      chk("b2 rx", cnt[4], pc(m[15:8]));
      chk("b1 take", cnt[11], pc(m[7:0]));
      chk("maint rx", cnt[5], 1);
      chk("aux rx", cnt[6], 1);
      chk("rate clk", cnt[8], 0);
      chk("idle oe", tx_oe, 0);
    end
    pending <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk("request", req, 1);
    frame(21, 0);
    chk("granted abort", cnt[7], 0);
    frame(21, 12);
    chk("abort", cnt[7], 1);
    apb(1'h0, isdtb_pkg::A_STAT, 32'h0);
    chk("abort count", rd[15:8], 8'h01);
    frame(21, 8);
    chk("abort at d", cnt[7], 1);
    pending <= 1'h0;
    apb(1'h1, isdtb_pkg::A_MASK, 32'hFFFF);
    apb(1'h1, isdtb_pkg::A_CTRL, 32'h2);
    frame(21, 0);
    chk("echo oe", cnt[2], 160);
    apb(1'h1, isdtb_pkg::A_CTRL, 32'h4);
    ser_tx <= 3'h0;
    frame(21, 0);
    chk("loop ones", cnt[9], 0);
    chk("loop b1", cnt[3], 8);
    seed = xs(seed);
    m = seed[15:0];
    apb(1'h1, isdtb_pkg::A_CTRL, 32'h1);
    apb(1'h1, isdtb_pkg::A_MASK, {16'h0, m});
    pending <= 1'h1;
    frame(193, 0);
    chk("rate clk gci", cnt[8], 193);
    chk("b1 gci", cnt[3], pc(m[7:0]));
    chk("b2 gci", cnt[4], pc(m[15:8]));
    chk("b1 take gci", cnt[11], pc(m[7:0]));
    chk("monitor", cnt[5], 8);
    chk("cmd ind", cnt[6], 6);
    chk("drain high", cnt[10], 0);
    chk("gci request", req, 0);
    report_and_stop();
  end
endmodule
